// ### dv/psd_bridge_test.sv
// self-checking bench for the program space data access bridge
`timescale 1ns/100ps
module psd_bridge_test;
   // notes: cpu result (flags err/miss, data, mask, cycles), memory strobe, apb answer
   typedef struct {logic [1:0] f; logic [15:0] d; logic [15:0] m; int lat; time t0;} psd_note_s;
   typedef struct {logic ee; logic [23:0] a; logic [15:0] d; logic [23:0] v;} psd_wr_s;
   typedef struct {logic rd; logic err; logic [31:0] d;} psd_apb_s;
   psd_note_s cq[$];
   psd_wr_s wq[$];
   psd_apb_s aq[$];
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   // bench copies of the registers that shape expectations
   logic [7:0] tpag = 8'h00;
   logic [7:0] wpag = 8'h00;
   logic win_en = 1'b0;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, cpu_ready, cpu_done, cpu_err, cpu_miss;
   logic cpu_req = 1'b0, cpu_byte = 1'b0, cpu_ee = 1'b0, cpu_move = 1'b0, cpu_rpt_mid = 1'b0;
   logic [2:0] cpu_op = 3'h0;
   logic [15:0] cpu_ea = 16'h0, cpu_wdata = 16'h0;
   logic [15:0] cpu_rdata, ee_addr, ee_wdata, ee_rdata;
   logic pm_rd, pm_wr, ee_rd, ee_wr;
   logic [23:0] pm_addr, pm_wdata, pm_rdata;
   logic [2:0] pm_be;

   always #25 pclk = ~pclk;

   psd_bridge dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cpu_req, .cpu_op, .cpu_byte, .cpu_ea, .cpu_wdata, .cpu_ee,
      .cpu_move, .cpu_rpt_mid, .cpu_ready, .cpu_done, .cpu_err, .cpu_miss, .cpu_rdata,
      .pm_rd, .pm_wr, .pm_addr, .pm_wdata, .pm_be, .pm_rdata, .ee_rd, .ee_wr, .ee_addr,
      .ee_wdata, .ee_rdata);
   psd_mem_model u_mem (.pclk, .pm_rd, .pm_addr, .pm_rdata, .ee_rd, .ee_addr, .ee_rdata);

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic report_and_stop;
      // a note never answered means a lost result, strobe or apb answer
      chk("pending notes", 0, cq.size() + wq.size() + aq.size());
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one apb transfer, held until pready; cpu work drains first so copies stay valid
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         input logic err, input logic [31:0] e);
      int n;
      n = 0;
      while (cq.size() != 0) begin
         @(posedge pclk);
         n++;
      end
      aq.push_back('{!wr, err, e});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      if (wr && a == psd_pkg::ADDR_TABLE_PAGE) tpag = wd[7:0];
      if (wr && a == psd_pkg::ADDR_WINDOW_PAGE) wpag = wd[7:0];
      if (wr && a == psd_pkg::ADDR_CORE_CTRL) win_en = wd[psd_pkg::CORE_WIN_EN_BIT];
   endtask

   // one cpu operation; the note is worked out before the request goes out
   task automatic op(input logic [2:0] o, input logic b, input logic ee, input logic mv,
         input logic rpt, input logic [15:0] ea, input logic [15:0] wd);
      psd_note_s nt;
      psd_wr_s w;
      logic [23:0] a, pw;
      int n;
      a = {tpag, ea[15:1], 1'b0};
      pw = u_mem.pm_word(a);
      nt = '{2'b00, 16'h0, b ? 16'h00ff : 16'hffff, 1, 0};
      w = '{ee, ee ? {8'h0, ea} : a, ee ? wd : 16'h4, {wd[7:0], 16'h0}};
      case (o)
         psd_pkg::OP_DATA_READ: begin
            pw = u_mem.pm_word({1'b0, wpag, ea[14:0]});
            nt.f = (ea[15] && win_en) ? 2'b00 : 2'b01;
            nt.d = nt.f[0] ? 16'h0 : pw[15:0];
            nt.lat = nt.f[0] ? 1 : ((mv || rpt) ? 4 : 5);
         end
         psd_pkg::OP_TRD_LOW: begin
            nt.lat = 3;
            if (ee) nt.d = u_mem.ee_word(ea);
            else if (tpag[7] && (ea < psd_pkg::CFG_IMPL_LO || ea > psd_pkg::CFG_IMPL_HI))
               nt.d = 16'h0;
            else nt.d = b ? {8'h0, ea[0] ? pw[15:8] : pw[7:0]} : pw[15:0];
         end
         psd_pkg::OP_TRD_HIGH: begin
            nt.f = ee ? 2'b10 : 2'b00;
            nt.lat = ee ? 1 : 3;
            nt.d = (ee || (b && ea[0])) ? 16'h0 : {8'h0, pw[23:16]};
         end
         default: begin
            if ((tpag[7] && !ee) || (o == psd_pkg::OP_TWR_HIGH && ee)) nt.f = 2'b10;
            else begin
               if (!ee && o == psd_pkg::OP_TWR_LOW) w.d = b ? {15'h0, ea[0]} + 16'h1 : 16'h3;
               if (o == psd_pkg::OP_TWR_LOW) w.v = b ? {8'h0, wd[7:0], wd[7:0]} : {8'h0, wd};
               if (!ee && o == psd_pkg::OP_TWR_HIGH && b && ea[0]) w.d = 16'h0;
               wq.push_back(w);
            end
         end
      endcase
      @(posedge pclk);
      cpu_req <= 1'b1;
      cpu_op <= o;
      cpu_byte <= b;
      cpu_ee <= ee;
      cpu_move <= mv;
      cpu_rpt_mid <= rpt;
      cpu_ea <= ea;
      cpu_wdata <= wd;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (cpu_ready !== 1'b1);
      nt.t0 = $time;
      cq.push_back(nt);
      cpu_req <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // watcher: takes the oldest note whenever a result shows at the outputs
   always @(posedge pclk) begin
      psd_note_s nt;
      psd_wr_s w;
      psd_apb_s ap;
      logic [23:0] ln;
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
      if (cpu_done === 1'b1) begin
         if (cq.size() == 0) chk("spare cpu result", 0, 1);
         else begin
            nt = cq.pop_front();
            chk("cpu flags", nt.f, {cpu_err, cpu_miss});
            chk("cpu data", nt.d, cpu_rdata & nt.m);
            if (nt.lat != 0) chk("cpu cycles", nt.lat, ($time - nt.t0) / 50);
         end
      end
      if (pm_wr === 1'b1 || ee_wr === 1'b1) begin
         if (wq.size() == 0) chk("spare strobe", 0, 1);
         else begin
            w = wq.pop_front();
            chk("write place", w.a, w.ee ? {8'h0, ee_addr} : pm_addr);
            chk("write lanes", w.d, w.ee ? ee_wdata : {13'h0, pm_be});
            // only the enabled lanes of the program word carry written data
            ln = {{8{pm_be[2]}}, {8{pm_be[1]}}, {8{pm_be[0]}}};
            if (!w.ee) chk("write data", w.v & ln, pm_wdata & ln);
         end
      end
      if (psel && penable && pready === 1'b1) begin
         if (aq.size() == 0) chk("spare apb answer", 0, 1);
         else begin
            ap = aq.pop_front();
            chk("apb error", ap.err, pslverr);
            if (ap.rd) chk("apb data", ap.d, prdata);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] r;
      void'($urandom(19));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      // reset values and an unmapped place
      apb(0, psd_pkg::ADDR_TABLE_PAGE, 0, 0, {24'h0, psd_pkg::TABLE_PAGE_RST});
      apb(0, psd_pkg::ADDR_WINDOW_PAGE, 0, 0, {24'h0, psd_pkg::WINDOW_PAGE_RST});
      apb(0, psd_pkg::ADDR_CORE_CTRL, 0, 0, {16'h0, psd_pkg::CORE_CTRL_RST});
      apb(0, psd_pkg::ADDR_STATUS, 0, 0, 0);
      apb(1, 8'h10, 32'h4, 1, 0);
      apb(0, 8'h10, 0, 1, 0);
      $display("registers test done");
      // table reads and writes in user space, every width and byte select
      apb(1, psd_pkg::ADDR_TABLE_PAGE, {25'h0, 7'($urandom)}, 0, 0);
      apb(0, psd_pkg::ADDR_TABLE_PAGE, 0, 0, {24'h0, tpag});
      for (int i = 0; i < 16; i++) begin
         r = 16'($urandom);
         op(i[2] ? psd_pkg::OP_TRD_HIGH : psd_pkg::OP_TRD_LOW, i[1], 0, 0, 0,
            {r[15:1], i[0]}, 0);
         op(i[2] ? psd_pkg::OP_TWR_HIGH : psd_pkg::OP_TWR_LOW, i[1], 0, 0, 0,
            {r[15:1], i[0]}, 16'($urandom));
      end
      $display("table test done");
      // eeprom: low ops reach it, high ops are refused and flagged
      r = 16'($urandom);
      op(psd_pkg::OP_TWR_LOW, 0, 1, 0, 0, r, ~r);
      op(psd_pkg::OP_TRD_LOW, 0, 1, 0, 0, r, 0);
      op(psd_pkg::OP_TRD_HIGH, 0, 1, 0, 0, r, 0);
      op(psd_pkg::OP_TWR_HIGH, 0, 1, 0, 0, r, r);
      apb(0, psd_pkg::ADDR_STATUS, 0, 0, 32'h1 << psd_pkg::STAT_EE_REF_BIT);
      apb(1, psd_pkg::ADDR_STATUS, 32'h1 << psd_pkg::STAT_EE_REF_BIT, 0, 0);
      apb(0, psd_pkg::ADDR_STATUS, 0, 0, 0);
      $display("eeprom test done");
      // configuration space: reads at implemented places only, writes refused
      apb(1, psd_pkg::ADDR_TABLE_PAGE, {24'h0, 1'b1, 7'($urandom)}, 0, 0);
      op(psd_pkg::OP_TRD_LOW, 0, 0, 0, 0, psd_pkg::CFG_IMPL_LO + 16'h2, 0);
      op(psd_pkg::OP_TRD_LOW, 0, 0, 0, 0, 16'h1234, 0);
      op(psd_pkg::OP_TWR_LOW, 0, 0, 0, 0, psd_pkg::CFG_IMPL_LO, 16'h55aa);
      op(psd_pkg::OP_TWR_HIGH, 1, 0, 0, 0, psd_pkg::CFG_IMPL_HI, 16'h00aa);
      apb(0, psd_pkg::ADDR_STATUS, 0, 0, 32'h1 << psd_pkg::STAT_CFG_REF_BIT);
      apb(1, psd_pkg::ADDR_STATUS, 32'h1 << psd_pkg::STAT_CFG_REF_BIT, 0, 0);
      apb(0, psd_pkg::ADDR_STATUS, 0, 0, 0);
      $display("configuration test done");
      // window: miss while disabled, then every instruction kind back to back
      apb(1, psd_pkg::ADDR_WINDOW_PAGE, {24'h0, 8'($urandom)}, 0, 0);
      op(psd_pkg::OP_DATA_READ, 0, 0, 0, 0, 16'h8000, 0);
      apb(1, psd_pkg::ADDR_CORE_CTRL, 32'h1 << psd_pkg::CORE_WIN_EN_BIT, 0, 0);
      apb(0, psd_pkg::ADDR_CORE_CTRL, 0, 0, 32'h1 << psd_pkg::CORE_WIN_EN_BIT);
      for (int i = 0; i < 8; i++) begin
         r = 16'($urandom);
         op(psd_pkg::OP_DATA_READ, 0, 0, i[0], i[1], {i[2], r[14:0]}, 0);
      end
      op(psd_pkg::OP_DATA_READ, 0, 0, 0, 0, 16'h7fff, 0);
      op(psd_pkg::OP_DATA_READ, 0, 0, 1, 0, 16'hffff, 0);
      $display("window test done");
      repeat (20) @(posedge pclk);
      report_and_stop();
   end
endmodule

// ### dv/psd_mem_model.sv
// program memory array and data eeprom standing on the far side of the bridge
`timescale 1ns/100ps
module psd_mem_model (
   input wire logic pclk,
   input wire logic pm_rd,
   input wire logic [23:0] pm_addr,
   output logic [23:0] pm_rdata,
   input wire logic ee_rd,
   input wire logic [15:0] ee_addr,
   output logic [15:0] ee_rdata
);
   // stored program word; upper byte all ones or all zeros so stray execution is a no-op
   function automatic logic [23:0] pm_word(input logic [23:0] a);
      return {{8{a[1]}}, a[15:0] ^ {a[23:16], a[23:16]} ^ 16'h3c5a};
   endfunction
   // stored eeprom word
   function automatic logic [15:0] ee_word(input logic [15:0] a);
      return ~a ^ 16'h0f0f;
   endfunction
   initial begin
      pm_rdata = 24'h000000;
      ee_rdata = 16'h0000;
   end
   // answer in the cycle after the strobe; otherwise toggle so stale data never matches
   always @(posedge pclk) begin
      pm_rdata <= pm_rd ? pm_word(pm_addr) : ~pm_rdata;
      ee_rdata <= ee_rd ? ee_word(ee_addr) : ~ee_rdata;
   end
endmodule

// ### rtl/psd_bridge.sv
// program space data access bridge: table operations and visibility window
`timescale 1ns/100ps
module psd_bridge (
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu data path
   input wire logic cpu_req,
   input wire logic [2:0] cpu_op,
   input wire logic cpu_byte,
   input wire logic [15:0] cpu_ea,
   input wire logic [15:0] cpu_wdata,
   input wire logic cpu_ee,
   input wire logic cpu_move,
   input wire logic cpu_rpt_mid,
   output logic cpu_ready,
   output logic cpu_done,
   output logic cpu_err,
   output logic cpu_miss,
   output logic [15:0] cpu_rdata,
   // program memory array
   output logic pm_rd,
   output logic pm_wr,
   output logic [23:0] pm_addr,
   output logic [23:0] pm_wdata,
   output logic [2:0] pm_be,
   input wire logic [23:0] pm_rdata,
   // data eeprom
   output logic ee_rd,
   output logic ee_wr,
   output logic [15:0] ee_addr,
   output logic [15:0] ee_wdata,
   input wire logic [15:0] ee_rdata
);
   ////////////////////////////////////////////////////////////////////////
   // registers and state
   logic [7:0] table_page_register; // table page
   logic [7:0] window_page_register; // window page
   logic [15:0] cpu_core_control; // core control, bit 2 enables window
   logic cfg_ref; // sticky: config write refused
   logic ee_ref; // sticky: high op on eeprom refused
   psd_pkg::psd_state_e state; // sequencer state
   logic [1:0] pad_cnt; // pad cycles left
   logic is_win; // operation is a window read
   logic is_ee; // operation goes to eeprom
   logic cfg_void; // unimplemented config read
   logic op_high; // latched high op
   logic op_byte; // latched byte mode
   logic op_bsel; // latched byte select

   psd_lane_if lane_bus ();

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   wire apb_setup = psel & ~penable;
   wire apb_take = psel & penable & pready;
   wire apb_wr = apb_take & pwrite;
   wire hit_tpag = paddr == psd_pkg::ADDR_TABLE_PAGE;
   wire hit_wpag = paddr == psd_pkg::ADDR_WINDOW_PAGE;
   wire hit_core = paddr == psd_pkg::ADDR_CORE_CTRL;
   wire hit_stat = paddr == psd_pkg::ADDR_STATUS;
   wire hit_any = hit_tpag | hit_wpag | hit_core | hit_stat;
   wire busy = state != psd_pkg::ST_IDLE;
   wire [31:0] status_word = {29'h0, ee_ref, cfg_ref, busy};
   wire [31:0] next_prdata = hit_tpag ? {24'h0, table_page_register} :
                              hit_wpag ? {24'h0, window_page_register} :
                              hit_core ? {16'h0, cpu_core_control} :
                              hit_stat ? status_word : 32'h0;

   ////////////////////////////////////////////////////////////////////////
   // cpu request decode
   wire take = cpu_req & cpu_ready;
   wire op_tbl = (cpu_op == psd_pkg::OP_TRD_LOW) | (cpu_op == psd_pkg::OP_TRD_HIGH) |
                 (cpu_op == psd_pkg::OP_TWR_LOW) | (cpu_op == psd_pkg::OP_TWR_HIGH);
   wire op_wr = (cpu_op == psd_pkg::OP_TWR_LOW) | (cpu_op == psd_pkg::OP_TWR_HIGH);
   wire op_hi = (cpu_op == psd_pkg::OP_TRD_HIGH) | (cpu_op == psd_pkg::OP_TWR_HIGH);
   // window needs both the address msb and the enable bit
   wire win_on = cpu_ea[psd_pkg::EA_MSB] &
                 cpu_core_control[psd_pkg::CORE_WIN_EN_BIT];
   wire win_rd = (cpu_op == psd_pkg::OP_DATA_READ) & win_on;
   wire cfg_sp = table_page_register[psd_pkg::TPAG_CFG_BIT];
   wire cfg_impl = (cpu_ea >= psd_pkg::CFG_IMPL_LO) & (cpu_ea <= psd_pkg::CFG_IMPL_HI);
   wire cfg_wr_bad = op_tbl & op_wr & cfg_sp & ~cpu_ee;
   wire ee_hi_bad = op_tbl & op_hi & cpu_ee;
   wire refuse = cfg_wr_bad | ee_hi_bad;
   wire plain_rd = (cpu_op == psd_pkg::OP_DATA_READ) & ~win_on;
   // table address: page on top, ea word address below, bit 0 forced to zero
   wire [23:0] tbl_addr = {table_page_register, cpu_ea[15:1], 1'b0};
   // window address: page supplies upper bits, 15 ea bits the lower
   wire [23:0] win_addr = {1'b0, window_page_register, cpu_ea[14:0]};
   wire [1:0] win_pad = cpu_rpt_mid ? 2'h0 :
                        cpu_move ? psd_pkg::WIN_PAD_MOVE : psd_pkg::WIN_PAD_OTHER;
   wire [2:0] wr_be = op_hi ? ((cpu_byte & cpu_ea[0]) ? psd_pkg::BE_NONE :
                               psd_pkg::BE_HIGH_BYTE) :
                      ~cpu_byte ? psd_pkg::BE_LOW_WORD :
                      cpu_ea[0] ? psd_pkg::BE_LOW_BYTE1 : psd_pkg::BE_LOW_BYTE0;
   wire [23:0] wr_data = op_hi ? {cpu_wdata[7:0], 16'h0000} :
                         cpu_byte ? {8'h00, cpu_wdata[7:0], cpu_wdata[7:0]} :
                         {8'h00, cpu_wdata};
   // sequencer next state
   wire go_fetch = take & ~refuse & ~plain_rd & ~(op_tbl & op_wr);
   wire fin_wait = (state == psd_pkg::ST_WAIT) & (pad_cnt == 2'h0);
   wire fin_pad = (state == psd_pkg::ST_PAD) & (pad_cnt == 2'h1);
   wire finish = fin_wait | fin_pad;

   ////////////////////////////////////////////////////////////////////////
   // lane selection of the returned word
   assign lane_bus.word = cfg_void ? 24'h0 : (is_ee ? {8'h00, ee_rdata} : pm_rdata);
   assign lane_bus.high_op = op_high & ~is_win;
   assign lane_bus.byte_mode = op_byte & ~is_win;
   assign lane_bus.bsel = op_bsel;

   psd_lane_sel u_lane (
      .lp(lane_bus)
   );

   ////////////////////////////////////////////////////////////////////////
   // apb answer: ready one cycle after setup, read data loaded then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup & ~hit_any;
         if (apb_setup) begin
            prdata <= next_prdata;
         end
      end
   end

   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_page_register <= psd_pkg::TABLE_PAGE_RST;
         window_page_register <= psd_pkg::WINDOW_PAGE_RST;
         cpu_core_control <= psd_pkg::CORE_CTRL_RST;
      end else if (apb_wr) begin
         if (hit_tpag) begin
            table_page_register <= pwdata[7:0];
         end
         if (hit_wpag) begin
            window_page_register <= pwdata[7:0];
         end
         if (hit_core) begin
            cpu_core_control <= pwdata[15:0];
         end
      end
   end

   // sticky refusal flags: a new refusal wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ref <= 1'b0;
         ee_ref <= 1'b0;
      end else begin
         if (take & cfg_wr_bad) begin
            cfg_ref <= 1'b1;
         end else if (apb_wr & hit_stat & pwdata[psd_pkg::STAT_CFG_REF_BIT]) begin
            cfg_ref <= 1'b0;
         end
         if (take & ee_hi_bad) begin
            ee_ref <= 1'b1;
         end else if (apb_wr & hit_stat & pwdata[psd_pkg::STAT_EE_REF_BIT]) begin
            ee_ref <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer: one operation at a time, so a window read never overlaps
   // a table operation in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= psd_pkg::ST_IDLE;
         pad_cnt <= 2'h0;
         is_win <= 1'b0;
         is_ee <= 1'b0;
         cfg_void <= 1'b0;
         op_high <= 1'b0;
         op_byte <= 1'b0;
         op_bsel <= 1'b0;
      end else begin
         case (state)
            psd_pkg::ST_IDLE: begin
               if (go_fetch) begin
                  state <= psd_pkg::ST_FETCH;
                  is_win <= win_rd;
                  is_ee <= cpu_ee & ~win_rd;
                  cfg_void <= ~win_rd & ~cpu_ee & cfg_sp & ~cfg_impl;
                  op_high <= op_hi;
                  op_byte <= cpu_byte;
                  op_bsel <= cpu_ea[0];
                  pad_cnt <= win_rd ? win_pad : 2'h0;
               end
            end
            psd_pkg::ST_FETCH: begin
               // a window read fetches twice, costing one extra cycle
               state <= is_win ? psd_pkg::ST_FETCH2 : psd_pkg::ST_WAIT;
            end
            psd_pkg::ST_FETCH2: begin
               state <= psd_pkg::ST_WAIT;
            end
            psd_pkg::ST_WAIT: begin
               state <= (pad_cnt == 2'h0) ? psd_pkg::ST_IDLE : psd_pkg::ST_PAD;
            end
            psd_pkg::ST_PAD: begin
               pad_cnt <= pad_cnt - 2'h1;
               if (pad_cnt == 2'h1) begin
                  state <= psd_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= psd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // memory strobes: reads pulse in fetch states, writes on acceptance
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_rd <= 1'b0;
         pm_wr <= 1'b0;
         pm_addr <= 24'h0;
         pm_wdata <= 24'h0;
         pm_be <= psd_pkg::BE_NONE;
         ee_rd <= 1'b0;
         ee_wr <= 1'b0;
         ee_addr <= 16'h0;
         ee_wdata <= 16'h0;
      end else begin
         pm_rd <= (go_fetch & ~(cpu_ee & ~win_rd) & ~(cfg_sp & ~cfg_impl & ~win_rd)) |
                  ((state == psd_pkg::ST_FETCH) & is_win);
         pm_wr <= take & op_wr & ~refuse & ~cpu_ee;
         ee_rd <= go_fetch & cpu_ee & ~win_rd;
         ee_wr <= take & op_wr & ~refuse & cpu_ee;
         if (take) begin
            pm_addr <= win_rd ? win_addr : tbl_addr;
            pm_wdata <= wr_data;
            pm_be <= op_wr ? wr_be : psd_pkg::BE_NONE;
            ee_addr <= cpu_ea;
            ee_wdata <= cpu_wdata;
         end
      end
   end

   // cpu answer: done pulses one cycle, ready drops while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_ready <= 1'b0;
         cpu_done <= 1'b0;
         cpu_err <= 1'b0;
         cpu_miss <= 1'b0;
         cpu_rdata <= 16'h0;
      end else begin
         cpu_ready <= go_fetch ? 1'b0 : (~busy | finish);
         cpu_done <= (take & ~go_fetch) | finish;
         cpu_err <= take & refuse;
         cpu_miss <= take & plain_rd;
         if (state == psd_pkg::ST_WAIT) begin
            cpu_rdata <= lane_bus.data;
         end else if (take) begin
            cpu_rdata <= 16'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_win_two_fetch: assert property (
      (state == psd_pkg::ST_FETCH) && is_win |-> pm_rd ##1 pm_rd)
      else $error("window read did not fetch twice");
   a_win_addr_map: assert property (
      take && win_rd |=> pm_addr == {1'b0, $past(window_page_register), $past(cpu_ea[14:0])})
      else $error("window address mapping wrong");
   a_tbl_addr_map: assert property (
      take && op_tbl |=> pm_addr[23:16] == $past(table_page_register))
      else $error("table page not applied");
   a_cfg_no_write: assert property (
      take && cfg_wr_bad |=> !pm_wr && cpu_err && cpu_done)
      else $error("configuration write not refused");
   a_ee_high_refused: assert property (
      take && ee_hi_bad |=> !ee_wr && !ee_rd && cfg_ref == $past(cfg_ref) && ee_ref)
      else $error("high op on eeprom not refused");
   a_win_gate: assert property (
      take && (cpu_op == psd_pkg::OP_DATA_READ) && !cpu_core_control[psd_pkg::CORE_WIN_EN_BIT]
      |=> cpu_miss && !pm_rd)
      else $error("window used while disabled");
   a_high_phantom: assert property (
      (state == psd_pkg::ST_WAIT) && op_high && op_byte && op_bsel && !is_win
      |=> cpu_rdata == 16'h0000)
      else $error("phantom byte not zero");
   a_high_word_top: assert property (
      (state == psd_pkg::ST_WAIT) && !is_win |=> cpu_rdata[15:8] == 8'h00 || !$past(op_high)
      || $past(op_byte))
      else $error("high word upper byte not zero");
   a_win_low16: assert property (
      (state == psd_pkg::ST_WAIT) && is_win && !cfg_void && !is_ee
      |=> cpu_rdata == $past(pm_rdata[15:0]))
      else $error("window data not lower sixteen bits");
   a_win_move_len: assert property (
      take && win_rd && cpu_move && !cpu_rpt_mid |-> ##4 cpu_done)
      else $error("move window read length wrong");
   a_win_other_len: assert property (
      take && win_rd && !cpu_move && !cpu_rpt_mid |=> !cpu_done [*4] ##1 cpu_done)
      else $error("other window read length wrong");
   a_busy_no_take: assert property (
      busy |-> !cpu_ready)
      else $error("request accepted while busy");

   c_win_read: cover property (take && win_rd);
   c_tbl_high_byte: cover property (take && cpu_op == psd_pkg::OP_TRD_HIGH && cpu_byte);
   c_ee_write: cover property (ee_wr);
   c_cfg_refused: cover property (take && cfg_wr_bad);
endmodule

// ### rtl/psd_lane_if.sv
// interface carrying one lane selection request and its result
`timescale 1ns/100ps
interface psd_lane_if;
   logic [23:0] word; // fetched program or eeprom word
   logic high_op; // high table operation
   logic byte_mode; // byte wide operation
   logic bsel; // byte select
   logic [15:0] data; // data result
   modport user (output word, output high_op, output byte_mode, output bsel, input data);
   modport lane (input word, input high_op, input byte_mode, input bsel, output data);
endinterface

// ### rtl/psd_lane_sel.sv
// byte and word lane selection of a fetched program word
`timescale 1ns/100ps
module psd_lane_sel (
   psd_lane_if.lane lp
);
   ////////////////////////////////////////////////////////////////////////
   // candidate results per mode
   wire [15:0] low_word = lp.word[15:0];
   wire [15:0] low_byte = {8'h00, (lp.bsel ? lp.word[15:8] : lp.word[7:0])};
   wire [15:0] high_word = {8'h00, lp.word[23:16]};
   // phantom byte has no storage behind it, so it reads zero
   wire [15:0] high_byte = lp.bsel ? 16'h0000 : {8'h00, lp.word[23:16]};
   wire [15:0] low_res = lp.byte_mode ? low_byte : low_word;
   wire [15:0] high_res = lp.byte_mode ? high_byte : high_word;
   // high ops see the upper byte space, low ops the word space
   assign lp.data = lp.high_op ? high_res : low_res;
endmodule

// ### rtl/psd_pkg.sv
// constants, opcodes and state type for the program space data access bridge
// Overview of operation
// - word table_read_low returns program bits 15:0
// - byte table_read_low: byte select picks byte
// - word table_read_high: program 23:16, upper zero
// - byte table_read_high: phantom byte reads zero
// - program word steps by two addresses
// - low ops: low word; high ops: upper byte
// - low ops reach eeprom; high ops refused
// - table page bit 7 selects configuration space
// - configuration space: reads only, implemented locations
// - window needs address msb and enable bit
// - window page forms upper program address bits
// - window covers data addresses 8000h and up
// - window read needs a second program fetch
// - window read returns lower sixteen bits only
// - window access waits during table operations
// - move adds one cycle, others add two (a mid-repeat window read adds one)
package psd_pkg;
   // apb register byte addresses
   localparam logic [7:0] ADDR_TABLE_PAGE = 8'h00;
   localparam logic [7:0] ADDR_WINDOW_PAGE = 8'h04;
   localparam logic [7:0] ADDR_CORE_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   // field positions
   localparam int CORE_WIN_EN_BIT = 2;
   localparam int TPAG_CFG_BIT = 7;
   localparam int EA_MSB = 15;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_CFG_REF_BIT = 1;
   localparam int STAT_EE_REF_BIT = 2;
   // reset values
   localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
   localparam logic [7:0] WINDOW_PAGE_RST = 8'h00;
   localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
   // cpu operation codes
   localparam logic [2:0] OP_DATA_READ = 3'h0;
   localparam logic [2:0] OP_TRD_LOW = 3'h1;
   localparam logic [2:0] OP_TRD_HIGH = 3'h2;
   localparam logic [2:0] OP_TWR_LOW = 3'h3;
   localparam logic [2:0] OP_TWR_HIGH = 3'h4;
   // window pad cycles beyond the second fetch
   localparam logic [1:0] WIN_PAD_MOVE = 2'h0;
   localparam logic [1:0] WIN_PAD_OTHER = 2'h1;
   // implemented configuration locations (values arbitrary)
   localparam logic [15:0] CFG_IMPL_LO = 16'hff00;
   localparam logic [15:0] CFG_IMPL_HI = 16'hff03;
   // byte enables over the 24-bit program word
   localparam logic [2:0] BE_LOW_WORD = 3'h3;
   localparam logic [2:0] BE_LOW_BYTE0 = 3'h1;
   localparam logic [2:0] BE_LOW_BYTE1 = 3'h2;
   localparam logic [2:0] BE_HIGH_BYTE = 3'h4;
   localparam logic [2:0] BE_NONE = 3'h0;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_FETCH2,
      ST_WAIT,
      ST_PAD
   } psd_state_e;
endpackage
